// *** design/crf_alu.v ***
// eight-bit arithmetic and logic unit with flag outputs
`include "crf_regs.vh"

module crf_alu (
    input  wire [3:0] op,
    input  wire [7:0] opa,
    input  wire [7:0] opb,
    input  wire       cin,
    output reg  [7:0] res,
    output reg        hc,
    output reg        cout,
    output reg        upd_h,
    output reg        upd_c
);
    reg [8:0] wide;
    reg [4:0] nib;

    always @* begin
        wide  = 9'h000;
        nib   = 5'h00;
        res   = 8'h00;
        hc    = 1'b0;
        cout  = 1'b0;
        upd_h = 1'b0;
        upd_c = 1'b0;
        case (op)
            `CRF_ALU_ADD, `CRF_ALU_ADC: begin
                wide  = {1'b0, opa} + {1'b0, opb}
                      + {8'h00, cin & op[0]};
                nib   = {1'b0, opa[3:0]} + {1'b0, opb[3:0]}
                      + {4'h0, cin & op[0]};
                res   = wide[7:0];
                hc    = nib[4];
                cout  = wide[8];
                upd_h = 1'b1;
                upd_c = 1'b1;
            end
            `CRF_ALU_SUB, `CRF_ALU_SBC, `CRF_ALU_NEG: begin
                if (op == `CRF_ALU_NEG)
                    wide = 9'h000 - {1'b0, opa};
                else
                    wide = {1'b0, opa} - {1'b0, opb}
                         - {8'h00, cin & op[0]};
                res   = wide[7:0];
                cout  = wide[8];
                upd_c = 1'b1;
            end
            `CRF_ALU_AND: res = opa & opb;
            `CRF_ALU_OR:  res = opa | opb;
            `CRF_ALU_XOR: res = opa ^ opb;
            `CRF_ALU_LD:  res = opb;
            `CRF_ALU_CPL: res = ~opa;
            `CRF_ALU_INC: res = opa + `CRF_ONE8;
            `CRF_ALU_DEC: res = opa - `CRF_ONE8;
            `CRF_ALU_SLL: begin
                res   = {opa[6:0], 1'b0};
                cout  = opa[7];
                upd_c = 1'b1;
            end
            `CRF_ALU_SRL: begin
                res   = {1'b0, opa[7:1]};
                cout  = opa[0];
                upd_c = 1'b1;
            end
            `CRF_ALU_RLC: begin
                res   = {opa[6:0], cin};
                cout  = opa[7];
                upd_c = 1'b1;
            end
            default: begin
                res   = {cin, opa[7:1]};
                cout  = opa[0];
                upd_c = 1'b1;
            end
        endcase
    end
endmodule

// *** design/crf_branch.v ***
// branch condition test on the condition flags
`include "crf_regs.vh"

module crf_branch (
    input  wire [3:0] cond,
    input  wire [7:0] flags,
    output reg        taken
);
    always @* begin
        case (cond)
            `CRF_BR_ALWAYS: taken = 1'b1;
            `CRF_BR_H:      taken = flags[`CRF_CC_H];
            `CRF_BR_NH:     taken = ~flags[`CRF_CC_H];
            `CRF_BR_MI:     taken = flags[`CRF_CC_N];
            `CRF_BR_PL:     taken = ~flags[`CRF_CC_N];
            `CRF_BR_EQ:     taken = flags[`CRF_CC_Z];
            `CRF_BR_NE:     taken = ~flags[`CRF_CC_Z];
            `CRF_BR_C:      taken = flags[`CRF_CC_C];
            `CRF_BR_NC:     taken = ~flags[`CRF_CC_C];
            default:        taken = 1'b0;
        endcase
    end
endmodule

// *** design/crf_core_regs.v ***
// programmer-visible core registers, flags and context stack sequencer
//
// Notes on behaviour
// - six working registers, not memory mapped, reached only by commands.
// - eight-bit accumulator feeds and receives alu operations.
// - two eight-bit index registers, address forming or scratch data.
// - interrupt context save and restore never touch the second index.
// - sixteen-bit program counter split into low and high bytes.
// - eight-bit flag register, reset 111x1xxx, bits 7 and 6 read one.
// - whole flag register pushable and poppable; flags set and tested singly.
// - add and add-with-carry set half carry from bit 3 carry, else clear.
// - branches taken on half carry set or clear.
// - negative flag copies bit 7 of each alu result.
// - zero flag set when the alu result is zero, else cleared.
// - carry flag shows arithmetic overflow or borrow; hardware or software.
// - set/clear carry, carry branches, bit test, shifts and rotates use carry.
// - branches on minus, plus, equal and not equal.
// - bits 5,3 give priority: 10 main, 01 one, 00 two, 11 disabled.
// - interrupt entry loads priority bits from the serviced source.
// - priority changed by enable, disable, return, halt, wait, pop.
// - stack pointer high byte forced, points at next free, resets 01FF.
// - call pushes two bytes, interrupt pushes five starting with pc low.
`include "crf_regs.vh"

module crf_core_regs (
    input  wire        clk,
    input  wire        nrst,
    input  wire        alu_valid,
    input  wire [3:0]  alu_op,
    input  wire [1:0]  alu_src,
    input  wire [1:0]  alu_dst,
    input  wire [7:0]  alu_operand,
    input  wire        wr_en,
    input  wire [2:0]  wr_sel,
    input  wire [7:0]  wr_data,
    input  wire [2:0]  flag_op,
    input  wire        bit_test_valid,
    input  wire        bit_test_value,
    input  wire        br_valid,
    input  wire [3:0]  br_cond,
    input  wire [7:0]  br_offset,
    output wire        br_taken,
    input  wire        pc_inc,
    input  wire        pc_load,
    input  wire [15:0] pc_load_val,
    input  wire        sp_dec,
    input  wire        sp_inc,
    input  wire        sp_rst,
    input  wire        irq_entry,
    input  wire [1:0]  irq_priority,
    input  wire        call_entry,
    input  wire        interrupt_return_instr_start,
    input  wire        ret_start,
    output wire        seq_busy,
    output wire        stk_we,
    output wire        stk_re,
    output wire [15:0] stk_addr,
    output wire [7:0]  stk_wdata,
    input  wire [7:0]  stk_rdata,
    output wire [7:0]  accumulator,
    output wire [7:0]  index_first,
    output wire [7:0]  index_second,
    output wire [15:0] program_counter,
    output wire [7:0]  condition_flags,
    output wire [15:0] stack_pointer
);
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_PUSH = 2'h1;
    localparam [1:0] ST_POP  = 2'h2;

    reg  [7:0]  a_q, a_d, x_q, x_d, y_q, y_d, cc_q, cc_d, sp_q, sp_d;
    reg  [15:0] pc_q, pc_d;
    reg  [1:0]  st_q, st_d;
    reg  [2:0]  len_q, len_d, step_q, step_d;
    reg         irq_q, irq_d;
    reg  [1:0]  pri_q, pri_d;
    reg         cap_q, cap_d;
    reg  [2:0]  cap_idx_q, cap_idx_d;
    reg         we_q, we_d, re_q, re_d;
    reg  [15:0] addr_q, addr_d;
    reg  [7:0]  wdata_q, wdata_d;
    reg  [7:0]  opa;
    reg  [7:0]  ctx_byte;
    wire [2:0]  pop_idx;
    wire        last_step;
    wire [7:0]  alu_res;
    wire        alu_h, alu_c, alu_upd_h, alu_upd_c;

    ////////////////////////////////////////////////////////////////////////
    // datapath helpers

    always @* begin
        case (alu_src)
            `CRF_SRC_X: opa = x_q;
            `CRF_SRC_Y: opa = y_q;
            default:    opa = a_q;
        endcase
    end

    crf_alu u_alu (
        .op    (alu_op),
        .opa   (opa),
        .opb   (alu_operand),
        .cin   (cc_q[`CRF_CC_C]),
        .res   (alu_res),
        .hc    (alu_h),
        .cout  (alu_c),
        .upd_h (alu_upd_h),
        .upd_c (alu_upd_c)
    );

    crf_branch u_branch (
        .cond  (br_cond),
        .flags (cc_q),
        .taken (br_taken)
    );

    // pops walk the push order backwards
    assign pop_idx   = len_q - `CRF_STEP_ONE - step_q;
    assign last_step = (step_q == len_q - `CRF_STEP_ONE);

    // second index is absent from the context on purpose
    always @* begin
        case (st_q == ST_POP ? pop_idx : step_q)
            `CRF_CTX_PCL: ctx_byte = pc_q[7:0];
            `CRF_CTX_PCH: ctx_byte = pc_q[15:8];
            `CRF_CTX_X:   ctx_byte = x_q;
            `CRF_CTX_A:   ctx_byte = a_q;
            default:      ctx_byte = cc_q;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // next state of registers; later statements take priority

    always @* begin
        a_d = a_q;
        x_d = x_q;
        y_d = y_q;
        pc_d = pc_q;
        cc_d = cc_q;  // untouched flags hold
        sp_d = sp_q;
        st_d = st_q;
        len_d = len_q;
        step_d = step_q;
        irq_d = irq_q;
        pri_d = pri_q;
        cap_d = 1'b0;
        cap_idx_d = cap_idx_q;
        we_d = 1'b0;
        re_d = 1'b0;
        addr_d = addr_q;
        wdata_d = wdata_q;

        if (pc_inc)
            pc_d = pc_q + `CRF_ONE16;
        if (br_valid && br_taken)
            pc_d = pc_q + {{8{br_offset[7]}}, br_offset};
        if (pc_load)
            pc_d = pc_load_val;

        if (alu_valid) begin
            case (alu_dst)
                `CRF_DST_A: a_d = alu_res;
                `CRF_DST_X: x_d = alu_res;
                `CRF_DST_Y: y_d = alu_res;
                default:    a_d = a_q;
            endcase
            cc_d[`CRF_CC_N] = alu_res[7];
            cc_d[`CRF_CC_Z] = (alu_res == 8'h00);
            if (alu_upd_h)
                cc_d[`CRF_CC_H] = alu_h;
            if (alu_upd_c)
                cc_d[`CRF_CC_C] = alu_c;
        end
        if (bit_test_valid)
            cc_d[`CRF_CC_C] = bit_test_value;

        case (flag_op)
            `CRF_FOP_SCF: cc_d[`CRF_CC_C] = 1'b1;
            `CRF_FOP_RCF: cc_d[`CRF_CC_C] = 1'b0;
            `CRF_FOP_SIM:
                {cc_d[`CRF_CC_PH], cc_d[`CRF_CC_PL]} =
                    `CRF_PRI_LEVEL3;
            `CRF_FOP_RIM, `CRF_FOP_HALT, `CRF_FOP_WFI:
                {cc_d[`CRF_CC_PH], cc_d[`CRF_CC_PL]} =
                    `CRF_PRI_LEVEL0;
            default: cc_d = cc_d;
        endcase

        if (wr_en) begin
            case (wr_sel)
                `CRF_WR_A:   a_d = wr_data;
                `CRF_WR_X:   x_d = wr_data;
                `CRF_WR_Y:   y_d = wr_data;
                `CRF_WR_PCL: pc_d[7:0] = wr_data;
                `CRF_WR_PCH: pc_d[15:8] = wr_data;
                `CRF_WR_CC:  cc_d = wr_data | `CRF_CC_FIXED;
                `CRF_WR_SPL: sp_d = wr_data;
                default:     a_d = a_d;
            endcase
        end

        if (sp_rst)
            sp_d = `CRF_SP_LO_RESET;
        else if (sp_dec)
            sp_d = sp_q - `CRF_ONE8;
        else if (sp_inc)
            sp_d = sp_q + `CRF_ONE8;

        case (st_q)
            ST_IDLE: begin
                step_d = 3'h0;
                if (irq_entry || call_entry) begin
                    st_d = ST_PUSH;
                    irq_d = irq_entry;
                    pri_d = irq_priority;
                    len_d = irq_entry ? `CRF_LEN_IRQ : `CRF_LEN_CALL;
                end else if (interrupt_return_instr_start || ret_start) begin
                    st_d = ST_POP;
                    irq_d = interrupt_return_instr_start;
                    len_d = interrupt_return_instr_start ? `CRF_LEN_IRQ : `CRF_LEN_CALL;
                end
            end
            ST_PUSH: begin
                // write at the free slot, then move down
                we_d = 1'b1;
                addr_d = {`CRF_SP_HIGH, sp_q};
                wdata_d = ctx_byte;
                sp_d = sp_q - `CRF_ONE8;
                step_d = step_q + `CRF_STEP_ONE;
                if (last_step) begin
                    st_d = ST_IDLE;
                    // old flags were pushed before the level changes
                    if (irq_q)
                        {cc_d[`CRF_CC_PH], cc_d[`CRF_CC_PL]} =
                            pri_q;
                end
            end
            ST_POP: begin
                re_d = 1'b1;
                addr_d = {`CRF_SP_HIGH, sp_q + `CRF_ONE8};
                sp_d = sp_q + `CRF_ONE8;
                cap_d = 1'b1;
                cap_idx_d = pop_idx;
                step_d = step_q + `CRF_STEP_ONE;
                if (last_step)
                    st_d = ST_IDLE;
            end
            default: st_d = ST_IDLE;
        endcase

        // read data is captured in the same cycle as the read strobe
        if (cap_q) begin
            case (cap_idx_q)
                `CRF_CTX_PCL: pc_d[7:0] = stk_rdata;
                `CRF_CTX_PCH: pc_d[15:8] = stk_rdata;
                `CRF_CTX_X:   x_d = stk_rdata;
                `CRF_CTX_A:   a_d = stk_rdata;
                default:      cc_d = stk_rdata | `CRF_CC_FIXED;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state registers

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            a_q <= `CRF_REG_RESET;
            x_q <= `CRF_REG_RESET;
            y_q <= `CRF_REG_RESET;
            pc_q <= `CRF_PC_RESET;
            cc_q <= `CRF_CC_RESET;
            sp_q <= `CRF_SP_LO_RESET;
            st_q <= ST_IDLE;
            len_q <= 3'h0;
            step_q <= 3'h0;
            irq_q <= 1'b0;
            pri_q <= 2'h0;
            cap_q <= 1'b0;
            cap_idx_q <= 3'h0;
            we_q <= 1'b0;
            re_q <= 1'b0;
            addr_q <= 16'h0000;
            wdata_q <= 8'h00;
        end else begin
            a_q <= a_d;
            x_q <= x_d;
            y_q <= y_d;
            pc_q <= pc_d;
            cc_q <= cc_d;
            sp_q <= sp_d;
            st_q <= st_d;
            len_q <= len_d;
            step_q <= step_d;
            irq_q <= irq_d;
            pri_q <= pri_d;
            cap_q <= cap_d;
            cap_idx_q <= cap_idx_d;
            we_q <= we_d;
            re_q <= re_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign seq_busy        = (st_q != ST_IDLE) | cap_q;
    assign stk_we          = we_q;
    assign stk_re          = re_q;
    assign stk_addr        = addr_q;
    assign stk_wdata       = wdata_q;
    assign accumulator     = a_q;
    assign index_first     = x_q;
    assign index_second    = y_q;
    assign program_counter = pc_q;
    assign condition_flags = cc_q;
    assign stack_pointer   = {`CRF_SP_HIGH, sp_q};
endmodule

// *** design/crf_regs.vh ***
// constants shared by the core register set and its helpers
`ifndef CRF_REGS_VH
`define CRF_REGS_VH

// condition flag bit positions
`define CRF_CC_C        0
`define CRF_CC_Z        1
`define CRF_CC_N        2
`define CRF_CC_PL       3
`define CRF_CC_H        4
`define CRF_CC_PH       5
`define CRF_CC_ONE_LO   6
`define CRF_CC_ONE_HI   7
// undefined reset bits are taken as zero
`define CRF_CC_RESET    8'hE8
`define CRF_CC_FIXED    8'hC0

// priority field values {high, low}
`define CRF_PRI_LEVEL0  2'h2
`define CRF_PRI_LEVEL3  2'h3

`define CRF_SP_HIGH     8'h01
`define CRF_SP_LO_RESET 8'hFF
`define CRF_REG_RESET   8'h00
`define CRF_PC_RESET    16'h0000
`define CRF_ONE8        8'h01
`define CRF_ONE16       16'h0001

// alu operations
`define CRF_ALU_ADD     4'h0
`define CRF_ALU_ADC     4'h1
`define CRF_ALU_SUB     4'h2
`define CRF_ALU_SBC     4'h3
`define CRF_ALU_AND     4'h4
`define CRF_ALU_OR      4'h5
`define CRF_ALU_XOR     4'h6
`define CRF_ALU_LD      4'h7
`define CRF_ALU_CPL     4'h8
`define CRF_ALU_NEG     4'h9
`define CRF_ALU_INC     4'hA
`define CRF_ALU_DEC     4'hB
`define CRF_ALU_SLL     4'hC
`define CRF_ALU_SRL     4'hD
`define CRF_ALU_RLC     4'hE
`define CRF_ALU_RRC     4'hF

// alu operand source and destination
`define CRF_SRC_A       2'h0
`define CRF_SRC_X       2'h1
`define CRF_SRC_Y       2'h2
`define CRF_DST_A       2'h0
`define CRF_DST_X       2'h1
`define CRF_DST_Y       2'h2
`define CRF_DST_NONE    2'h3

// direct register write select
`define CRF_WR_A        3'h0
`define CRF_WR_X        3'h1
`define CRF_WR_Y        3'h2
`define CRF_WR_PCL      3'h3
`define CRF_WR_PCH      3'h4
`define CRF_WR_CC       3'h5
`define CRF_WR_SPL      3'h6

// flag instructions
`define CRF_FOP_NONE    3'h0
`define CRF_FOP_SCF     3'h1
`define CRF_FOP_RCF     3'h2
`define CRF_FOP_RIM     3'h3
`define CRF_FOP_SIM     3'h4
`define CRF_FOP_HALT    3'h5
`define CRF_FOP_WFI     3'h6

// branch conditions
`define CRF_BR_ALWAYS   4'h0
`define CRF_BR_NEVER    4'h1
`define CRF_BR_H        4'h2
`define CRF_BR_NH       4'h3
`define CRF_BR_MI       4'h4
`define CRF_BR_PL       4'h5
`define CRF_BR_EQ       4'h6
`define CRF_BR_NE       4'h7
`define CRF_BR_C        4'h8
`define CRF_BR_NC       4'h9

// context byte index, in push order
`define CRF_CTX_PCL     3'h0
`define CRF_CTX_PCH     3'h1
`define CRF_CTX_X       3'h2
`define CRF_CTX_A       3'h3
`define CRF_CTX_CC      3'h4
`define CRF_LEN_IRQ     3'h5
`define CRF_LEN_CALL    3'h2
`define CRF_STEP_ONE    3'h1

`endif

// *** test/crf_regs_checker.sv ***
// concurrent checks on the core register set ports
`include "crf_regs.vh"
module crf_regs_checker (
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic        alu_valid,
    input wire logic [3:0]  alu_op,
    input wire logic [1:0]  alu_src,
    input wire logic [1:0]  alu_dst,
    input wire logic [7:0]  alu_operand,
    input wire logic        wr_en,
    input wire logic [2:0]  flag_op,
    input wire logic        bit_test_valid,
    input wire logic [3:0]  br_cond,
    input wire logic        br_taken,
    input wire logic        irq_entry,
    input wire logic [1:0]  irq_priority,
    input wire logic        seq_busy,
    input wire logic        stk_we,
    input wire logic [15:0] stk_addr,
    input wire logic [7:0]  stk_wdata,
    input wire logic [7:0]  accumulator,
    input wire logic [7:0]  index_second,
    input wire logic [15:0] program_counter,
    input wire logic [7:0]  condition_flags,
    input wire logic [15:0] stack_pointer
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    wire [4:0] nib = {1'b0, accumulator[3:0]} + {1'b0, alu_operand[3:0]};
    wire       nib_c = nib[4];
    wire [7:0] program_counter_low = program_counter[7:0];
    wire [7:0] sp_lo = stack_pointer[7:0];
    wire       calm = !wr_en && !seq_busy;
    // flag ops and bit test outrank the alu flags
    wire quiet = calm && !bit_test_valid && flag_op == `CRF_FOP_NONE;
    wire is_scf = flag_op == `CRF_FOP_SCF;
    wire is_sim = flag_op == `CRF_FOP_SIM;
    wire pri_op = flag_op >= `CRF_FOP_RIM;
    sequence irq_go;
        irq_entry && !seq_busy;
    endsequence
    sequence push_five;
        stk_we [*5] ##1 !stk_we;
    endsequence
    chk_fixed_ones: assert property (condition_flags[7:6] == 2'h3)
        else $error("flag bits 7:6 not one");
    chk_sp_high: assert property (stack_pointer[15:8] == 8'h01)
        else $error("stack high byte wrong");
    chk_reset_vals: assert property ($rose(nrst) |->
        condition_flags == 8'hE8 && stack_pointer == 16'h01FF)
        else $error("reset values wrong");
    chk_add_half: assert property (alu_valid && quiet &&
        alu_op == `CRF_ALU_ADD && alu_src == `CRF_SRC_A
        |=> condition_flags[4] == $past(nib_c))
        else $error("half carry wrong");
    chk_nz_result: assert property (alu_valid && quiet &&
        alu_dst == `CRF_DST_A |=> condition_flags[2] == accumulator[7]
        && condition_flags[1] == (accumulator == 8'h00))
        else $error("negative or zero flag wrong");
    chk_carry_cmd: assert property (calm && flag_op != 3'h0 &&
        flag_op <= `CRF_FOP_RCF |=> condition_flags[0] == $past(is_scf))
        else $error("carry command wrong");
    chk_prio_cmd: assert property (calm && pri_op |=>
        {condition_flags[5], condition_flags[3]} == {1'b1, $past(is_sim)})
        else $error("priority command wrong");
    chk_irq_push: assert property (irq_go |=> ##1 push_five)
        else $error("interrupt push length wrong");
    chk_irq_first: assert property (irq_go |-> ##2
        stk_addr == $past(stack_pointer, 2) && stk_wdata == $past(program_counter_low, 2))
        else $error("first pushed byte wrong");
    chk_irq_level: assert property (irq_go |-> ##6
        {condition_flags[5], condition_flags[3]} == $past(irq_priority, 6)
        && sp_lo == $past(sp_lo, 6) - 8'h05)
        else $error("priority load or stack depth wrong");
    chk_y_hold: assert property (seq_busy && !wr_en |=>
        $stable(index_second))
        else $error("second index changed by sequence");
    chk_br_equal: assert property (br_cond == `CRF_BR_EQ |->
        br_taken == condition_flags[1])
        else $error("equal branch wrong");
endmodule
bind crf_core_regs crf_regs_checker chk_u (.*);

// *** test/crf_stack_mem.sv ***
// stack memory model answering the core's push and pop strobes
module crf_stack_mem (
    input  wire logic        clk,
    input  wire logic        stk_we,
    input  wire logic        stk_re,
    input  wire logic [15:0] stk_addr,
    input  wire logic [7:0]  stk_wdata,
    output logic      [7:0]  stk_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:255];
    // idle shows the inverse, so a late capture is caught
    assign stk_rdata = stk_re ? mem[stk_addr[7:0]] : ~mem[stk_addr[7:0]];
    always @(posedge clk)
        if (stk_we)
            mem[stk_addr[7:0]] <= stk_wdata;
endmodule

// *** test/testbench.sv ***
// self-checking bench for the core register set
`include "crf_regs.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic av; logic [3:0] op; logic [1:0] src; logic [1:0] dst;
        logic [7:0] opnd; logic we; logic [2:0] sel; logic [7:0] wd;
        logic [2:0] fop; logic btv; logic btx; logic bv; logic [3:0] bc;
        logic [7:0] bo; logic pci; logic program_counter_low; logic [15:0] pcv;
        logic spd; logic spi; logic spr; logic irq; logic [1:0] pri;
        logic call; logic interrupt_return_instr; logic ret;
    } crf_cmd_t;
    logic clk, nrst, alu_valid, wr_en, bit_test_valid, bit_test_value;
    logic br_valid, pc_inc, pc_load, sp_dec, sp_inc, sp_rst, irq_entry;
    logic call_entry, interrupt_return_instr_start, ret_start, br_taken, seq_busy;
    logic stk_we, stk_re;
    logic [3:0] alu_op, br_cond;
    logic [1:0] alu_src, alu_dst, irq_priority;
    logic [2:0] wr_sel, flag_op;
    logic [7:0] alu_operand, wr_data, br_offset, stk_wdata, stk_rdata;
    logic [7:0] accumulator, index_first, index_second, condition_flags;
    logic [15:0] pc_load_val, stk_addr, program_counter, stack_pointer;
    logic [63:0] q [$];
    logic [63:0] n;
    logic [7:0] r [3];
    logic [7:0] cc_m, sp_m, a, b, sv_a, sv_x, sv_cc;
    logic [15:0] pc_m, sv_pc;
    logic [31:0] rnd;
    logic [8:0] s9;
    logic [4:0] h5;
    logic ci, t;
    crf_cmd_t c;
    int seed = 56810;
    int err_total = 0;
    int checks = 0;
    logic [3:0] ops [4] = '{`CRF_ALU_ADD, `CRF_ALU_ADC, `CRF_ALU_SUB,
                            `CRF_ALU_AND};
    crf_core_regs dut_u (.*);
    crf_stack_mem mem_u (.*);
    wire [63:0] seen = {accumulator, index_first, index_second,
                        program_counter, condition_flags, stack_pointer};
    ////////////////////////////////////////////////////////////////////////
    task automatic drive(input crf_cmd_t k);
        {alu_valid, alu_op, alu_src, alu_dst, alu_operand, wr_en, wr_sel,
         wr_data, flag_op, bit_test_valid, bit_test_value, br_valid,
         br_cond, br_offset, pc_inc, pc_load, pc_load_val, sp_dec, sp_inc,
         sp_rst, irq_entry, irq_priority, call_entry, interrupt_return_instr_start,
         ret_start} <= k;
    endtask
    // one command cycle, then idle; returns at the edge that took it
    task automatic run(input crf_cmd_t k);
        @(posedge clk);
        drive(k);
        @(posedge clk);
        drive('0);
    endtask
    task automatic chk_all;
        q.push_back({r[0], r[1], r[2], pc_m, cc_m, 8'h01, sp_m});
    endtask
    task automatic wr(input logic [2:0] s, input logic [7:0] d);
        crf_cmd_t k;
        k = '0;
        k.we = 1'b1;
        k.sel = s;
        k.wd = d;
        run(k);
        case (s)
            `CRF_WR_PCL: pc_m[7:0] = d;
            `CRF_WR_PCH: pc_m[15:8] = d;
            `CRF_WR_CC: cc_m = d | `CRF_CC_FIXED;
            `CRF_WR_SPL: sp_m = d;
            default: r[s] = d;
        endcase
    endtask
    task automatic seq(input crf_cmd_t k);
        int m;
        run(k);
        @(negedge clk);
        for (m = 0; m < 12 && seq_busy === 1'b1; m++)
            @(negedge clk);
        if (m == 12)
            err_total++;
        @(posedge clk);
    endtask
    task automatic report_and_stop;
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        #(25 * 5000);
        err_total++;
        report_and_stop();
    end
    always @(negedge clk) begin
        while (q.size() > 0) begin
            n = q.pop_front();
            checks++;
            if (n !== seen) begin
                err_total++;
                $display("[FAIL] registers exp %h got %h", n, seen);
            end
        end
    end
    initial begin
        nrst = 1'b0;
        drive('0);
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        r = '{8'h00, 8'h00, 8'h00};
        pc_m = 16'h0000;
        cc_m = 8'hE8;
        sp_m = 8'hFF;
        chk_all();
        for (int i = 0; i < 7; i++) begin
            wr(i[2:0], $random(seed));
            chk_all();
        end
        for (int i = 0; i < 32; i++) begin
            rnd = $random(seed);
            c = '0;
            c.av = 1'b1;
            c.op = ops[rnd[5:4]];
            c.src = (rnd[1:0] == 2'h3) ? 2'h0 : rnd[1:0];
            c.dst = rnd[3:2];
            c.opnd = rnd[15:8];
            run(c);
            a = r[c.src];
            b = c.opnd;
            ci = (c.op == `CRF_ALU_ADC) & cc_m[0];
            h5 = {1'b0, a[3:0]} + {1'b0, b[3:0]} + ci;
            case (c.op)
                `CRF_ALU_SUB: s9 = {1'b0, a} - {1'b0, b};
                `CRF_ALU_AND: s9 = {cc_m[0], a & b};
                default: s9 = {1'b0, a} + {1'b0, b} + ci;
            endcase
            if (c.op <= `CRF_ALU_ADC)
                cc_m[4] = h5[4];
            cc_m[2:0] = {s9[7], s9[7:0] == 8'h00, s9[8]};
            if (c.dst != `CRF_DST_NONE)
                r[c.dst] = s9[7:0];
            chk_all();
        end
        for (int i = 1; i < 9; i++) begin
            c = '0;
            c.fop = (i < 7) ? i[2:0] : 3'h0;
            c.btv = i > 6;
            c.btx = i[0];
            run(c);
            if (i < 3 || i > 6)
                cc_m[0] = i[0];
            else
                {cc_m[5], cc_m[3]} = (i == 4) ? 2'h3 : 2'h2;
            chk_all();
        end
        for (int k = 0; k < 2; k++) begin
            wr(`CRF_WR_CC, k ? 8'hFF : 8'h00);
            for (int j = 0; j < 10; j++) begin
                c = '0;
                c.bv = 1'b1;
                c.pci = 1'b1;
                c.bc = j[3:0];
                c.bo = $random(seed);
                run(c);
                case (j)
                    0: t = 1'b1;
                    1: t = 1'b0;
                    2, 3: t = cc_m[4] ^ j[0];
                    4, 5: t = cc_m[2] ^ j[0];
                    6, 7: t = cc_m[1] ^ j[0];
                    default: t = cc_m[0] ^ j[0];
                endcase
                pc_m = pc_m + (t ? {{8{c.bo[7]}}, c.bo} : 16'h0001);
                chk_all();
            end
        end
        for (int i = 0; i < 4; i++) begin
            c = '0;
            c.spr = i == 0;
            c.spi = i == 1;
            c.spd = i > 1;
            c.program_counter_low = i == 0;
            c.pcv = $random(seed);
            run(c);
            if (i == 0)
                pc_m = c.pcv;
            sp_m = (i == 0) ? 8'hFF : (i == 1) ? sp_m + 8'h01 : sp_m - 8'h01;
            chk_all();
        end
        {sv_a, sv_x, sv_pc, sv_cc} = {r[0], r[1], pc_m, cc_m};
        c = '0;
        c.irq = 1'b1;
        c.pri = $random(seed);
        seq(c);
        {cc_m[5], cc_m[3]} = c.pri;
        sp_m = sp_m - 8'h05;
        chk_all();
        for (int i = 0; i < 5; i++) begin
            wr(i[2:0], $random(seed));
        end
        c = '0;
        c.interrupt_return_instr = 1'b1;
        seq(c);
        {r[0], r[1], pc_m, cc_m} = {sv_a, sv_x, sv_pc, sv_cc};
        sp_m = sp_m + 8'h05;
        chk_all();
        sv_pc = pc_m;
        c = '0;
        c.call = 1'b1;
        seq(c);
        sp_m = sp_m - 8'h02;
        chk_all();
        wr(`CRF_WR_PCH, $random(seed));
        c = '0;
        c.ret = 1'b1;
        seq(c);
        pc_m = sv_pc;
        sp_m = sp_m + 8'h02;
        chk_all();
        repeat (2) @(negedge clk);
        report_and_stop();
    end
endmodule
